// ==== rtl/ctau_pkg.sv ====
// constants and types shared by the clock time arithmetic unit
package ctau_pkg;

	////////////////////////////////////////////////////////////////////////////
	// operation select, pulse or continuous form chosen separately
	typedef enum logic [2:0] {
		OP_TIME_SUBTRACT = 3'h0,
		OP_HMS_TO_SECONDS = 3'h1,
		OP_HMS_TO_SECONDS_WIDE = 3'h2,
		OP_SECONDS_TO_HMS = 3'h3,
		OP_SECONDS_TO_HMS_WIDE = 3'h4
	} ctau_op_t;

	////////////////////////////////////////////////////////////////////////////
	// time arithmetic constants
	localparam logic [31:0] SEC_PER_HOUR = 32'h00000e10;
	localparam logic [31:0] SEC_PER_MIN = 32'h0000003c;
	localparam logic [31:0] HOURS_PER_DAY = 32'h00000018;
	localparam logic [31:0] SEC_PER_DAY = 32'h00015180;
	localparam logic [15:0] FIELD_MAX_MS = 16'h003b;
	// largest count whose hour word still fits a positive 16-bit value
	localparam logic [31:0] SEC_MAX_WIDE = 32'h0707ffff;
	localparam logic [15:0] ERR_CODE_RANGE = 16'h1a32;

	////////////////////////////////////////////////////////////////////////////
	// register map, word offsets
	localparam logic [2:0] REG_STATUS = 3'h0;
	localparam logic [2:0] REG_MASK = 3'h1;
	localparam logic [2:0] REG_ERROR_CODE = 3'h2;
	localparam logic [2:0] REG_FLAGS = 3'h3;
	localparam logic [2:0] REG_RESULT0 = 3'h4;
	localparam logic [2:0] REG_RESULT1 = 3'h5;
	localparam logic [2:0] REG_RESULT2 = 3'h6;

	////////////////////////////////////////////////////////////////////////////
	// status, mask and flags bit positions
	localparam int ST_DONE = 0;
	localparam int ST_BORROW = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_ERROR = 3;
	localparam int ST_WIDTH = 4;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [3:0] RST_STATUS = 4'h0;
	localparam logic [3:0] RST_MASK = 4'h0;
	localparam logic [15:0] RST_ERROR_CODE = 16'h0000;
	localparam logic [15:0] RST_WORD = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// complete state of the unit
	typedef struct packed {
		logic en_prev;
		logic [15:0] res0;
		logic [15:0] res1;
		logic [15:0] res2;
		logic done;
		logic borrow;
		logic zero;
		logic op_err;
		logic [15:0] err_code;
		logic [3:0] status;
		logic [3:0] mask;
		logic [15:0] rdata;
		logic irq;
	} ctau_state_t;

endpackage

// ==== rtl/ctau_top.sv ====
// clock time arithmetic unit: time subtraction and h:m:s / seconds conversion
`timescale 1ns/1ps
`default_nettype none

// Function
// - subtraction operands and result are three 16-bit words: hour, minute, second
// - subtraction stores minuend minus subtrahend into the result triple
// - result below zero hours sets borrow and adds 24 hours
// - zero flag set when stored result is exactly 0:0:0
// - narrow hms-to-seconds writes total seconds into one result word
// - wide hms-to-seconds writes low half to base word, high half next
// - minute or second out of range raises error flag, code 6706
// - hms-to-seconds result is 16 or 32 bits depending on form
// - seconds-to-hms takes 16 or 32-bit seconds, gives 16-bit triple
// - seconds-to-hms writes three words; wide source high word is upper half
// - seconds source out of range raises error flag, code 6706
module ctau_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// instruction sequencer
	input wire logic exec_i,
	input wire logic pulse_mode_i,
	input wire logic [2:0] op_i,
	input wire logic [15:0] op_a_hour_i,
	input wire logic [15:0] op_a_min_i,
	input wire logic [15:0] op_a_sec_i,
	input wire logic [15:0] op_b_hour_i,
	input wire logic [15:0] op_b_min_i,
	input wire logic [15:0] op_b_sec_i,
	input wire logic [15:0] src_lo_i,
	input wire logic [15:0] src_hi_i,
	// results and flags
	output logic done_o,
	output logic [15:0] res0_o,
	output logic [15:0] res1_o,
	output logic [15:0] res2_o,
	output logic borrow_o,
	output logic zero_o,
	output logic op_err_o,
	output logic [15:0] err_code_o,
	// register port
	input wire logic [2:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// interrupt
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// state and trigger

	ctau_pkg::ctau_state_t cur_q;
	ctau_pkg::ctau_state_t nxt_d;
	logic fire;

	// pulse forms run once on the rising edge of the command, others each cycle
	assign fire = pulse_mode_i ? (exec_i & ~cur_q.en_prev) : exec_i;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [17:0] ds;
		logic [17:0] dm;
		logic [17:0] dh;
		logic [31:0] tot;
		logic [31:0] src;
		logic [31:0] rem;
		logic src_bad;
		logic [3:0] set_bits;
		logic bs;
		logic bm;
		ds = '0;
		dm = '0;
		dh = '0;
		tot = '0;
		src = '0;
		rem = '0;
		src_bad = 1'b0;
		set_bits = 4'h0;
		bs = 1'b0;
		bm = 1'b0;
		nxt_d = cur_q;
		nxt_d.en_prev = exec_i;
		nxt_d.done = 1'b0;
		nxt_d.rdata = ctau_pkg::RST_WORD;

		// software writes first so that hardware events below win
		if (wr_i) begin
			case (addr_i)
				ctau_pkg::REG_STATUS: begin
					nxt_d.status = cur_q.status & ~wdata_i[3:0];
				end
				ctau_pkg::REG_MASK: begin
					nxt_d.mask = wdata_i[3:0];
				end
				ctau_pkg::REG_ERROR_CODE: begin
					nxt_d.err_code = wdata_i;
				end
				default: begin
				end
			endcase
		end

		if (fire) begin
			nxt_d.done = 1'b1;
			set_bits[ctau_pkg::ST_DONE] = 1'b1;
			case (op_i)
				ctau_pkg::OP_TIME_SUBTRACT: begin
					// field-wise borrow chain, then wrap across one day
					ds = {2'b00, op_a_sec_i} - {2'b00, op_b_sec_i};
					// take each borrow before its field is corrected, or it is lost
					bs = ds[17];
					if (bs) begin
						ds = ds + ctau_pkg::SEC_PER_MIN[17:0];
					end
					dm = {2'b00, op_a_min_i} - {2'b00, op_b_min_i} - {17'h00000, bs};
					bm = dm[17];
					if (bm) begin
						dm = dm + ctau_pkg::SEC_PER_MIN[17:0];
					end
					dh = {2'b00, op_a_hour_i} - {2'b00, op_b_hour_i} - {17'h00000, bm};
					nxt_d.borrow = dh[17];
					if (dh[17]) begin
						dh = dh + ctau_pkg::HOURS_PER_DAY[17:0];
					end
					nxt_d.res0 = dh[15:0];
					nxt_d.res1 = dm[15:0];
					nxt_d.res2 = ds[15:0];
					nxt_d.zero = (dh == 18'h00000) && (dm == 18'h00000) && (ds == 18'h00000);
					nxt_d.op_err = 1'b0;
					set_bits[ctau_pkg::ST_BORROW] = nxt_d.borrow;
					set_bits[ctau_pkg::ST_ZERO] = nxt_d.zero;
				end
				ctau_pkg::OP_HMS_TO_SECONDS, ctau_pkg::OP_HMS_TO_SECONDS_WIDE: begin
					tot = 32'(op_a_hour_i) * ctau_pkg::SEC_PER_HOUR
						+ 32'(op_a_min_i) * ctau_pkg::SEC_PER_MIN
						+ 32'(op_a_sec_i);
					if ((op_a_min_i > ctau_pkg::FIELD_MAX_MS) ||
						(op_a_sec_i > ctau_pkg::FIELD_MAX_MS)) begin
						nxt_d.op_err = 1'b1;
						nxt_d.err_code = ctau_pkg::ERR_CODE_RANGE;
						set_bits[ctau_pkg::ST_ERROR] = 1'b1;
					end else begin
						nxt_d.op_err = 1'b0;
						nxt_d.res0 = tot[15:0];
						if (op_i == ctau_pkg::OP_HMS_TO_SECONDS_WIDE) begin
							nxt_d.res1 = tot[31:16];
						end
					end
				end
				ctau_pkg::OP_SECONDS_TO_HMS, ctau_pkg::OP_SECONDS_TO_HMS_WIDE: begin
					if (op_i == ctau_pkg::OP_SECONDS_TO_HMS_WIDE) begin
						src = {src_hi_i, src_lo_i};
						src_bad = src[31] || (src > ctau_pkg::SEC_MAX_WIDE);
					end else begin
						src = {{16{src_lo_i[15]}}, src_lo_i};
						src_bad = src_lo_i[15];
					end
					if (src_bad) begin
						nxt_d.op_err = 1'b1;
						nxt_d.err_code = ctau_pkg::ERR_CODE_RANGE;
						set_bits[ctau_pkg::ST_ERROR] = 1'b1;
					end else begin
						rem = src % ctau_pkg::SEC_PER_HOUR;
						tot = src / ctau_pkg::SEC_PER_HOUR;
						nxt_d.op_err = 1'b0;
						nxt_d.res0 = tot[15:0];
						tot = rem / ctau_pkg::SEC_PER_MIN;
						nxt_d.res1 = tot[15:0];
						tot = rem % ctau_pkg::SEC_PER_MIN;
						nxt_d.res2 = tot[15:0];
					end
				end
				default: begin
				end
			endcase
		end

		// sticky events: a set in the clearing cycle survives
		nxt_d.status = nxt_d.status | set_bits;
		nxt_d.irq = |(nxt_d.status & nxt_d.mask);

		if (rd_i) begin
			case (addr_i)
				ctau_pkg::REG_STATUS: nxt_d.rdata = {12'h000, cur_q.status};
				ctau_pkg::REG_MASK: nxt_d.rdata = {12'h000, cur_q.mask};
				ctau_pkg::REG_ERROR_CODE: nxt_d.rdata = cur_q.err_code;
				ctau_pkg::REG_FLAGS: nxt_d.rdata = {12'h000, cur_q.op_err, cur_q.zero,
					cur_q.borrow, 1'b0};
				ctau_pkg::REG_RESULT0: nxt_d.rdata = cur_q.res0;
				ctau_pkg::REG_RESULT1: nxt_d.rdata = cur_q.res1;
				ctau_pkg::REG_RESULT2: nxt_d.rdata = cur_q.res2;
				default: nxt_d.rdata = ctau_pkg::RST_WORD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_q.en_prev <= 1'b0;
			cur_q.res0 <= ctau_pkg::RST_WORD;
			cur_q.res1 <= ctau_pkg::RST_WORD;
			cur_q.res2 <= ctau_pkg::RST_WORD;
			cur_q.done <= 1'b0;
			cur_q.borrow <= 1'b0;
			cur_q.zero <= 1'b0;
			cur_q.op_err <= 1'b0;
			cur_q.err_code <= ctau_pkg::RST_ERROR_CODE;
			cur_q.status <= ctau_pkg::RST_STATUS;
			cur_q.mask <= ctau_pkg::RST_MASK;
			cur_q.rdata <= ctau_pkg::RST_WORD;
			cur_q.irq <= 1'b0;
		end else begin
			cur_q <= nxt_d;
		end
	end

	assign done_o = cur_q.done;
	assign res0_o = cur_q.res0;
	assign res1_o = cur_q.res1;
	assign res2_o = cur_q.res2;
	assign borrow_o = cur_q.borrow;
	assign zero_o = cur_q.zero;
	assign op_err_o = cur_q.op_err;
	assign err_code_o = cur_q.err_code;
	assign rdata_o = cur_q.rdata;
	assign irq_o = cur_q.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [31:0] a_tot;
	logic [31:0] b_tot;
	logic [31:0] r_tot;
	assign a_tot = 32'(op_a_hour_i) * ctau_pkg::SEC_PER_HOUR
		+ 32'(op_a_min_i) * ctau_pkg::SEC_PER_MIN + 32'(op_a_sec_i);
	assign b_tot = 32'(op_b_hour_i) * ctau_pkg::SEC_PER_HOUR
		+ 32'(op_b_min_i) * ctau_pkg::SEC_PER_MIN + 32'(op_b_sec_i);
	assign r_tot = 32'(res0_o) * ctau_pkg::SEC_PER_HOUR
		+ 32'(res1_o) * ctau_pkg::SEC_PER_MIN + 32'(res2_o);
	logic status_err_seen;
	assign status_err_seen = cur_q.status[ctau_pkg::ST_ERROR];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_sub_fire;
		fire && (op_i == ctau_pkg::OP_TIME_SUBTRACT);
	endsequence

	sequence s_hms_to_seconds_ok;
		fire && (op_i == ctau_pkg::OP_HMS_TO_SECONDS_WIDE)
			&& (op_a_min_i <= ctau_pkg::FIELD_MAX_MS) && (op_a_sec_i <= ctau_pkg::FIELD_MAX_MS);
	endsequence

	sequence s_seconds_to_hms_wide_ok;
		fire && (op_i == ctau_pkg::OP_SECONDS_TO_HMS_WIDE)
			&& ({src_hi_i, src_lo_i} <= ctau_pkg::SEC_MAX_WIDE);
	endsequence

	sequence s_seconds_to_hms_narrow_ok;
		fire && (op_i == ctau_pkg::OP_SECONDS_TO_HMS) && !src_lo_i[15];
	endsequence

	a_sub_value: assert property (s_sub_fire |=>
		((r_tot + $past(b_tot)) % ctau_pkg::SEC_PER_DAY) == ($past(a_tot) % ctau_pkg::SEC_PER_DAY))
		else $error("subtraction result wrong");
	a_sub_borrow: assert property (s_sub_fire |=> borrow_o == ($past(a_tot) < $past(b_tot)))
		else $error("borrow flag wrong");
	a_sub_zero: assert property (s_sub_fire |=>
		zero_o == ($past(a_tot) == $past(b_tot)))
		else $error("zero flag wrong");
	a_sub_fields: assert property (s_sub_fire |=>
		(res0_o < 16'h0018) && (res1_o <= ctau_pkg::FIELD_MAX_MS) && (res2_o <= ctau_pkg::FIELD_MAX_MS))
		else $error("subtraction field out of range");
	a_hms_to_seconds_wide: assert property (s_hms_to_seconds_ok |=> ({res1_o, res0_o} == $past(a_tot)) && !op_err_o)
		else $error("wide seconds total wrong");
	a_hms_to_seconds_narrow: assert property (fire && (op_i == ctau_pkg::OP_HMS_TO_SECONDS)
		&& (op_a_min_i <= ctau_pkg::FIELD_MAX_MS) && (op_a_sec_i <= ctau_pkg::FIELD_MAX_MS)
		|=> res0_o == $past(a_tot[15:0]) && $stable(res1_o))
		else $error("narrow seconds total wrong");
	a_hms_to_seconds_error: assert property (fire && (op_i == ctau_pkg::OP_HMS_TO_SECONDS)
		&& (op_a_sec_i > ctau_pkg::FIELD_MAX_MS) |=> op_err_o && (err_code_o == ctau_pkg::ERR_CODE_RANGE)
		&& $stable(res0_o) ##1 status_err_seen)
		else $error("range error not raised");
	a_seconds_to_hms_inverse: assert property (s_seconds_to_hms_wide_ok |=>
		(r_tot == $past({src_hi_i, src_lo_i})) && (res1_o < 16'h003c) && (res2_o < 16'h003c))
		else $error("seconds to hms wrong");
	a_seconds_to_hms_error: assert property (fire && (op_i == ctau_pkg::OP_SECONDS_TO_HMS) && src_lo_i[15]
		|=> op_err_o && (err_code_o == ctau_pkg::ERR_CODE_RANGE) && done_o)
		else $error("seconds range error not raised");
	a_done_pulse: assert property (fire |=> done_o ##1 (done_o == $past(fire)))
		else $error("done pulse wrong");
	a_irq_level: assert property (##1 irq_o == $past(|(nxt_d.status & nxt_d.mask)))
		else $error("interrupt level wrong");

	// error paths and held results
	a_hms_to_seconds_min_err: assert property (fire && ((op_i == ctau_pkg::OP_HMS_TO_SECONDS)
		|| (op_i == ctau_pkg::OP_HMS_TO_SECONDS_WIDE)) && (op_a_min_i > ctau_pkg::FIELD_MAX_MS)
		|=> op_err_o && (err_code_o == ctau_pkg::ERR_CODE_RANGE)
		&& $stable(res0_o) && $stable(res1_o))
		else $error("minute range error not raised");
	a_seconds_to_hms_narrow: assert property (s_seconds_to_hms_narrow_ok |=> (r_tot == $past({16'h0000, src_lo_i}))
		&& (res1_o < 16'h003c) && (res2_o < 16'h003c) && !op_err_o)
		else $error("narrow seconds to hms wrong");
	a_seconds_to_hms_wide_err: assert property (fire && (op_i == ctau_pkg::OP_SECONDS_TO_HMS_WIDE)
		&& ({src_hi_i, src_lo_i} > ctau_pkg::SEC_MAX_WIDE)
		|=> op_err_o && (err_code_o == ctau_pkg::ERR_CODE_RANGE) && $stable(res0_o))
		else $error("wide seconds range error not raised");
	a_sub_no_err: assert property (s_sub_fire |=> !op_err_o && done_o)
		else $error("subtraction raised an error");
	a_bad_op_keep: assert property (fire && (op_i > 3'h4) |=> done_o && $stable(res0_o)
		&& $stable(res1_o) && $stable(res2_o) && $stable(op_err_o))
		else $error("unused operation changed results");
	a_results_hold: assert property (!fire |=> $stable(res0_o) && $stable(res1_o)
		&& $stable(res2_o) && $stable(borrow_o) && $stable(zero_o) && $stable(op_err_o))
		else $error("results changed without an execution");

	// register port and interrupt
	a_done_status: assert property (fire |=> cur_q.status[ctau_pkg::ST_DONE])
		else $error("done status bit not set");
	a_status_sticky: assert property (status_err_seen && !(wr_i && (addr_i == ctau_pkg::REG_STATUS)
		&& wdata_i[ctau_pkg::ST_ERROR]) |=> status_err_seen)
		else $error("error status bit lost");
	a_mask_write: assert property (wr_i && (addr_i == ctau_pkg::REG_MASK) |=> cur_q.mask == $past(wdata_i[3:0]))
		else $error("mask write lost");
	a_rdata_idle: assert property (!rd_i |=> rdata_o == ctau_pkg::RST_WORD)
		else $error("read data not idle");
	a_rdata_err: assert property (rd_i && (addr_i == ctau_pkg::REG_ERROR_CODE) |=> rdata_o == $past(err_code_o))
		else $error("error code read wrong");

endmodule

`default_nettype wire

// ==== test/ctau_seq_model.sv ====
// partner model: instruction sequencer raising the command contact
`timescale 1ns/1ps
`default_nettype none
module ctau_seq_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench control: start, idle cycles before, cycles held high
	input wire logic go_i,
	input wire logic [3:0] delay_i,
	input wire logic [3:0] len_i,
	// command contact to the unit
	output logic exec_o
);
	logic [3:0] wait_q;
	logic [3:0] left_q;

	////////////////////////////////////////////////////////////////////////////
	// a slow sequencer waits delay_i scans, then holds the contact len_i scans
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_q <= 4'h0;
			left_q <= 4'h0;
		end else if (go_i) begin
			wait_q <= delay_i;
			left_q <= len_i;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end
	end
	assign exec_o = (wait_q == 4'h0) && (left_q != 4'h0);
endmodule
`default_nettype wire

// ==== test/ctau_top_tb.sv ====
// self-checking bench for the clock time arithmetic unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module ctau_top_tb;
	logic clk_i, rst_i, exec, pm, go, wr, rd, done, bor, zro, err, irq;
	logic [2:0] op, addr, o;
	logic [3:0] dly, len;
	logic [15:0] a_h, a_m, a_s, b_h, b_m, b_s, s_lo, s_hi, wd, r0, r1, r2, ecode, rdat, q;
	logic [15:0] e0, e1, e2;
	logic e_err, e_bor, e_zero, k1, k2;
	int mismatches, checks_done, n, i;

	ctau_seq_model seq (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .delay_i(dly), .len_i(len),
		.exec_o(exec));
	ctau_top dut (.clk_i(clk_i), .rst_i(rst_i), .exec_i(exec), .pulse_mode_i(pm), .op_i(op),
		.op_a_hour_i(a_h), .op_a_min_i(a_m), .op_a_sec_i(a_s), .op_b_hour_i(b_h),
		.op_b_min_i(b_m), .op_b_sec_i(b_s), .src_lo_i(s_lo), .src_hi_i(s_hi), .done_o(done),
		.res0_o(r0), .res1_o(r1), .res2_o(r2), .borrow_o(bor), .zero_o(zro), .op_err_o(err),
		.err_code_o(ecode), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdat), .irq_o(irq));

	////////////////////////////////////////////////////////////////////////////
	task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic lda(input logic [15:0] h1, m1, s1, h2, m2, s2);
		@(posedge clk_i);
		a_h <= h1;
		a_m <= m1;
		a_s <= s1;
		b_h <= h2;
		b_m <= m2;
		b_s <= s2;
	endtask
	task automatic lds(input logic [15:0] lo, hi);
		@(posedge clk_i);
		s_lo <= lo;
		s_hi <= hi;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// expected outcome worked out from the operands now on the ports
	task automatic expect_op(input logic [2:0] c);
		logic [31:0] ta, tb, v;
		ta = a_h * 32'he10 + a_m * 32'h3c + a_s;
		tb = b_h * 32'he10 + b_m * 32'h3c + b_s;
		v = (c == 3'h3) ? {{16{s_lo[15]}}, s_lo} : {s_hi, s_lo};
		case (c)
			3'h0: begin
				e_bor = ta < tb;
				v = e_bor ? ta + 32'h15180 - tb : ta - tb;
				e_zero = v == 32'h0;
				e_err = 1'b0;
			end
			3'h1, 3'h2: begin
				e_err = a_m > 16'h3b || a_s > 16'h3b;
				v = ta;
			end
			3'h3, 3'h4: e_err = v[31] || v > ctau_pkg::SEC_MAX_WIDE;
			default: ;
		endcase
		if (c <= 3'h4 && !e_err) begin
			if (c == 3'h1 || c == 3'h2) begin
				e0 = v[15:0];
				e1 = v[31:16];
				k1 = c == 3'h2;
				k2 = 1'b0;
			end else begin
				e0 = 16'(v / 32'he10);
				e1 = 16'((v % 32'he10) / 32'h3c);
				e2 = 16'(v % 32'h3c);
				k1 = 1'b1;
				k2 = 1'b1;
			end
		end
		`CHK("op_err", e_err, err)
		if (e_err) `CHK("err_code", 16'h1a32, ecode)
		`CHK("borrow", e_bor, bor)
		`CHK("zero", e_zero, zro)
		`CHK("result0", e0, r0)
		if (k1) `CHK("result1", e1, r1)
		if (k2) `CHK("result2", e2, r2)
	endtask

	task automatic run(input logic [2:0] c, input logic p, input logic [3:0] dl, ln);
		@(posedge clk_i);
		op <= c;
		pm <= p;
		dly <= dl;
		len <= ln;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge clk_i);
			#1 if (done === 1'b1) n++;
		end
		`CHK("done count", p ? 1 : int'(ln), n)
		expect_op(c);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		{rst_i, go, wr, rd, pm} = 5'h10;
		{op, addr, dly, len, wd} = '0;
		{a_h, a_m, a_s, b_h, b_m, b_s, s_lo, s_hi} = '0;
		{e0, e1, e2, e_err, e_bor, e_zero, k1, k2} = '0;
		{mismatches, checks_done} = '0;
		n = $urandom(96);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 8; i++) begin
			reg_rd(3'(i), q);
			`CHK("reset read", 16'h0000, q)
		end
		$display("test reset values ended");
		lda(16'ha, 16'h1e, 16'ha, 16'h3, 16'ha, 16'h5);
		run(3'h0, 1'b0, 4'h0, 4'h1);
		lda(16'h5, 16'h14, 16'h28, 16'h12, 16'ha, 16'h5);
		run(3'h0, 1'b1, 4'h2, 4'h3);
		lda(16'h6, 16'h0, 16'h0, 16'h6, 16'h0, 16'h0);
		run(3'h0, 1'b0, 4'h3, 4'h2);
		// one second below midnight: borrow runs through every field
		lda(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1);
		run(3'h0, 1'b1, 4'h1, 4'h1);
		lda(16'h4, 16'h1d, 16'h1f, 16'h0, 16'h0, 16'h0);
		run(3'h1, 1'b0, 4'h0, 4'h1);
		run(3'h2, 1'b1, 4'h0, 4'h2);
		lda(16'h23, 16'ha, 16'h3a, 16'h0, 16'h0, 16'h0);
		run(3'h2, 1'b0, 4'h1, 4'h1);
		lda(16'h1, 16'h3c, 16'h0, 16'h0, 16'h0, 16'h0);
		run(3'h1, 1'b0, 4'h0, 4'h1);
		lda(16'h1, 16'h0, 16'h3c, 16'h0, 16'h0, 16'h0);
		run(3'h2, 1'b0, 4'h0, 4'h1);
		run(3'h5, 1'b0, 4'h0, 4'h3);
		lds(16'h7153, 16'h0);
		run(3'h3, 1'b0, 4'h0, 4'h1);
		lds(16'h8000, 16'h0);
		run(3'h3, 1'b0, 4'h0, 4'h1);
		lds(16'h9c40, 16'h0);
		run(3'h4, 1'b1, 4'h0, 4'h1);
		lds(16'hffff, 16'h0707);
		run(3'h4, 1'b0, 4'h0, 4'h1);
		lds(16'h0000, 16'h0708);
		run(3'h4, 1'b0, 4'h0, 4'h1);
		$display("test directed operations ended");
		for (i = 0; i < 60; i++) begin
			o = 3'($urandom % 5);
			// operands of a subtraction stay within 0..23 and 0..59
			lda(16'($urandom % 24), 16'($urandom % (o == 3'h0 ? 60 : 64)),
				16'($urandom % (o == 3'h0 ? 60 : 64)), 16'($urandom % 24),
				16'($urandom % 60), 16'($urandom % 60));
			lds(16'($urandom), 16'($urandom % 16'h0800));
			run(o, 1'($urandom), 4'($urandom % 4), 4'(1 + $urandom % 3));
		end
		$display("test random operations ended");
		reg_wr(3'h1, 16'h0001);
		repeat (2) @(posedge clk_i);
		#1 `CHK("irq masked done", 1'b1, irq)
		reg_rd(3'h0, q);
		`CHK("status", 16'h000f, q)
		reg_wr(3'h0, 16'h000f);
		repeat (2) @(posedge clk_i);
		#1 `CHK("irq cleared", 1'b0, irq)
		reg_rd(3'h3, q);
		`CHK("flags", {12'h0, e_err, e_zero, e_bor, 1'b0}, q)
		reg_wr(3'h4, 16'h5a5a);
		reg_rd(3'h4, q);
		`CHK("result0 read only", e0, q)
		reg_rd(3'h7, q);
		`CHK("unmapped read", 16'h0000, q)
		reg_wr(3'h2, 16'h1234);
		reg_rd(3'h2, q);
		`CHK("err code write", 16'h1234, q)
		`CHK("err code port", 16'h1234, ecode)
		reg_wr(3'h1, 16'h0000);
		repeat (2) @(posedge clk_i);
		#1 `CHK("irq mask off", 1'b0, irq)
		$display("test registers and interrupt ended");
		give_verdict();
	end
endmodule
`default_nettype wire
